// ===== include/chan_if.sv
// Link between the register front end and one limit channel
`timescale 1ns/1ns
interface chan_if;
  import precip_pkg::*;
  chan_cfg_t cfg;
  logic en;
  logic tick;
  logic rain;
  logic force_evt;
  logic state;
  logic tx;
  logic busy;
  modport ctl (output cfg, en, tick, rain, force_evt, input state, tx, busy);
  modport ch (input cfg, en, tick, rain, force_evt, output state, tx, busy);
endinterface : chan_if

// ===== include/precip_consts.svh
// Offsets, field positions, reset values and timing counts of the block
// How it works
// - A control bit enables the sensor; when off no output is evaluated or sent.
// - Limit count selects none, output 1, or outputs 1 and 2, each own setup.
// - Per output, polarity chooses whether rain gives a 1 or a 0.
// - Switch-on delay picks none, 1s to 60min from fourteen choices.
// - Switch-off delay uses the same fourteen choices, set on its own.
// - A change to 1 is accepted and sent only after the on delay.
// - While the on delay runs, cyclic sends keep the old 0.
// - A change to 0 is accepted and sent only after the off delay.
// - While the off delay runs, cyclic sends keep the old 1.
// - With no-telegram set, change and cyclic sends are suppressed while the rain condition holds.
// - Send-on-change off means no send caused by a state change.
// - Send-on-change on sends every accepted transition in either direction, except a change to the rain state while no-telegram is set.
// - A cyclic setting of one or more sends periodically regardless of change.
// - The cyclic period is the setting times ten seconds.
// - A cyclic setting of zero disables periodic sending.
// - No send-on-change and cyclic zero means the output is sent only on supply loss and return.
// - A missing 24V supply makes the input read as rain.
// - Supply loss and return each force evaluation and send each output twice.
// - Each output is one bit showing the accepted limit state.
`ifndef PRECIP_CONSTS_SVH
`define PRECIP_CONSTS_SVH
`define REG_CTRL 8'h00
`define REG_CFG1 8'h04
`define REG_CFG2 8'h08
`define REG_STATUS 8'h0C
`define CTRL_EN_BIT 0
`define CTRL_CNT_LO 1
`define CTRL_W 3
`define CFG_W 18
`define CTRL_RST 3'h0
`define CFG_RST 18'h0_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define CYC_STEP_S 10
`endif

// ===== include/precip_pkg.sv
// Types shared by the limit output block
package precip_pkg;
  // Packed so that a configuration word maps bit for bit
  typedef struct packed {
    logic mute;
    logic [6:0] cyc;
    logic on_chg;
    logic [3:0] off_sel;
    logic [3:0] on_sel;
    logic pol;
  } chan_cfg_t;
endpackage : precip_pkg

// ===== rtl/limit_channel.sv
// One limit output: delays, change and cyclic sends, supply events
`timescale 1ns/1ns
`include "precip_consts.svh"
module limit_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  chan_if.ch port
);
  import precip_pkg::*;

  function automatic logic [11:0] delay_secs(input logic [3:0] sel);
    case (sel)
      4'h1: delay_secs = 12'h001;
      4'h2: delay_secs = 12'h003;
      4'h3: delay_secs = 12'h005;
      4'h4: delay_secs = 12'h00A;
      4'h5: delay_secs = 12'h00F;
      4'h6: delay_secs = 12'h01E;
      4'h7: delay_secs = 12'h03C;
      4'h8: delay_secs = 12'h0B4;
      4'h9: delay_secs = 12'h12C;
      4'hA: delay_secs = 12'h258;
      4'hB: delay_secs = 12'h384;
      4'hC: delay_secs = 12'h708;
      4'hD: delay_secs = 12'hE10;
      default: delay_secs = 12'h000;
    endcase
  endfunction : delay_secs

  logic state, primed, tx;
  logic [11:0] dly;
  logic [10:0] cyc;
  logic [1:0] pend;
  logic next_state, next_primed, next_tx;
  logic [11:0] next_dly;
  logic [10:0] next_cyc;
  logic [1:0] next_pend;
  logic target, mute, busy;
  logic [11:0] lim;
  logic [2:0] add;
  logic [2:0] sum;

  always_comb
  begin
    next_state = state;
    next_primed = primed;
    next_dly = dly;
    next_cyc = cyc;
    next_tx = 1'b0;
    add = 3'h0;
    target = port.cfg.pol ? port.rain : ~port.rain;
    mute = port.cfg.mute && (state == port.cfg.pol);
    lim = state ? delay_secs(port.cfg.off_sel) : delay_secs(port.cfg.on_sel);
    busy = primed && (target != state) && (lim != 12'h000);
    if (!port.en)
    begin
      next_state = ~port.cfg.pol;
      next_primed = 1'b0;
      next_dly = 12'h000;
      next_cyc = 11'h000;
    end
    else if (!primed)
    begin
      next_state = ~port.cfg.pol;
      next_primed = 1'b1;
    end
    else if (port.force_evt)
    begin
      // Supply events bypass the delays
      next_state = target;
      next_dly = 12'h000;
      next_cyc = 11'h000;
      add = 3'h2;
    end
    else
    begin
      if (target == state)
        next_dly = 12'h000;
      else if (lim == 12'h000 || (port.tick && dly + 12'h001 >= lim))
      begin
        next_state = target;
        next_dly = 12'h000;
        if (port.cfg.on_chg &&
            !(port.cfg.mute && target == port.cfg.pol))
          add = 3'h1;
      end
      else if (port.tick)
        next_dly = dly + 12'h001;
      // Cyclic sends carry the held state, so they repeat the old value
      if (port.cfg.cyc != 7'h00 && port.tick)
      begin
        if (cyc + 11'h001 >= 11'(port.cfg.cyc) * 11'(`CYC_STEP_S))
        begin
          next_cyc = 11'h000;
          if (!mute)
            add = add + 3'h1;
        end
        else
          next_cyc = cyc + 11'h001;
      end
      else if (port.cfg.cyc == 7'h00)
        next_cyc = 11'h000;
    end
    sum = {1'b0, pend} + add;
    next_pend = (sum > 3'h3) ? 2'h3 : sum[1:0];
    if (!port.en)
      next_pend = 2'h0;
    else if (next_pend != 2'h0)
    begin
      next_tx = 1'b1;
      next_pend = next_pend - 2'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= 1'b0;
      primed <= 1'b0;
      dly <= 12'h000;
      cyc <= 11'h000;
      pend <= 2'h0;
      tx <= 1'b0;
    end
    else
    begin
      state <= next_state;
      primed <= next_primed;
      dly <= next_dly;
      cyc <= next_cyc;
      pend <= next_pend;
      tx <= next_tx;
    end
  end

  assign port.state = state;
  assign port.tx = tx;
  assign port.busy = busy;
endmodule : limit_channel

// ===== rtl/precip_limit_output.sv
// Precipitation limit outputs with an AXI4-Lite register front end
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "precip_consts.svh"
module precip_limit_output #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rain_raw,
  input wire logic supply_ok,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] limit_out,
  output logic [1:0] tx_req
);
  import precip_pkg::*;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = data[b*8 +: 8];
    end
    merge = res;
  endfunction : merge

  // Input synchronisers and supply edge
  logic rain_s1, rain_s2, sup_s1, sup_s2, sup_d;
  logic next_rain_s1, next_rain_s2, next_sup_s1, next_sup_s2, next_sup_d;
  logic rain_eff, force_evt;

  always_comb
  begin
    next_rain_s1 = rain_raw;
    next_rain_s2 = rain_s1;
    next_sup_s1 = supply_ok;
    next_sup_s2 = sup_s1;
    next_sup_d = sup_s2;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rain_s1 <= 1'b0;
      rain_s2 <= 1'b0;
      // Supply taken as present, so release raises no false supply event
      sup_s1 <= 1'b1;
      sup_s2 <= 1'b1;
      sup_d <= 1'b1;
    end
    else
    begin
      rain_s1 <= next_rain_s1;
      rain_s2 <= next_rain_s2;
      sup_s1 <= next_sup_s1;
      sup_s2 <= next_sup_s2;
      sup_d <= next_sup_d;
    end
  end

  // No supply reads as rain
  assign rain_eff = rain_s2 | ~sup_s2;
  // Both loss and return of the supply trigger the double send
  assign force_evt = sup_s2 ^ sup_d;

  // One-second timebase
  logic [31:0] pre;
  logic [31:0] next_pre;
  logic tick, next_tick;

  always_comb
  begin
    next_tick = 1'b0;
    if (pre >= 32'(TICK_CYCLES - 1))
    begin
      next_pre = 32'h0000_0000;
      next_tick = 1'b1;
    end
    else
      next_pre = pre + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pre <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else
    begin
      pre <= next_pre;
      tick <= next_tick;
    end
  end

  // Register file and AXI4-Lite slave
  logic [`CTRL_W-1:0] ctrl;
  logic [`CFG_W-1:0] cfg1, cfg2;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [`CTRL_W-1:0] next_ctrl;
  logic [`CFG_W-1:0] next_cfg1, next_cfg2;
  logic next_aw_hold, next_w_hold;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] status;
  logic [1:0] busy;

  always_comb
  begin
    next_ctrl = ctrl;
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    status = {26'h000_0000, busy, limit_out, sup_s2, rain_eff};
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_hold && w_hold && !s_axi_bvalid)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      case (aw_addr)
        `REG_CTRL:
          next_ctrl = `CTRL_W'(merge(32'(ctrl), w_data, w_strb));
        `REG_CFG1:
          next_cfg1 = `CFG_W'(merge(32'(cfg1), w_data, w_strb));
        `REG_CFG2:
          next_cfg2 = `CFG_W'(merge(32'(cfg2), w_data, w_strb));
        default:
          next_bresp = `RESP_SLVERR;
      endcase
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL: next_rdata = 32'(ctrl);
        `REG_CFG1: next_rdata = 32'(cfg1);
        `REG_CFG2: next_rdata = 32'(cfg2);
        `REG_STATUS: next_rdata = status;
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    // Ready is registered, so a second request waits for the answer
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl <= `CTRL_RST;
      cfg1 <= `CFG_RST;
      cfg2 <= `CFG_RST;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Channels
  chan_if ch_bus[2] ();
  logic [1:0] cnt;
  assign cnt = ctrl[`CTRL_CNT_LO +: 2];

  assign ch_bus[0].cfg = chan_cfg_t'(cfg1);
  assign ch_bus[1].cfg = chan_cfg_t'(cfg2);
  assign ch_bus[0].en = ctrl[`CTRL_EN_BIT] && cnt != 2'h0;
  assign ch_bus[1].en = ctrl[`CTRL_EN_BIT] && cnt[1];

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    assign ch_bus[i].tick = tick;
    assign ch_bus[i].rain = rain_eff;
    assign ch_bus[i].force_evt = force_evt;
    // Channel state and send strobe are flip-flops inside the channel
    assign limit_out[i] = ch_bus[i].state;
    assign tx_req[i] = ch_bus[i].tx;
    assign busy[i] = ch_bus[i].busy;
    limit_channel u_ch (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .port(ch_bus[i])
    );
  end
endmodule : precip_limit_output

// ===== tb/precip_props.sv
// Port checks for the limit output block
`timescale 1ns/1ns
`include "precip_consts.svh"
module precip_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] limit_out,
  input wire logic [1:0] tx_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_RST_IDLE: assert property ($rose(rst_n) |->
    limit_out == 2'b00 && tx_req == 2'b00) else $error("not idle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rvalid dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_W_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_ERR_DATA: assert property (s_axi_rvalid &&
    s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read with data");
  AST_TX_BURST: assert property (tx_req[0] [*3] |=> !tx_req[0])
    else $error("send burst too long");
  cover property (tx_req[0] ##1 tx_req[0]);
  cover property ($fell(supply_ok));
  cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule : precip_props

// ===== tb/tb_top.sv
// Self-checking bench for the precipitation limit outputs
`timescale 1ns/1ns
`include "precip_consts.svh"
module tb_top;
  import precip_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rain_raw = 1'b0;
  logic supply_ok = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [1:0] limit_out;
  logic [1:0] tx_req;
  logic [7:0] cnt0;
  logic [7:0] cnt1;
  logic [1:0] sent;
  logic [31:0] rd_val;
  logic [7:0] b0;
  logic [7:0] b1;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  // A 20-cycle second keeps the delay and cycle tests short
  precip_limit_output #(.TICK_CYCLES(20)) DUT (.*);
  tx_sink SINK (.ref_clk(ref_clk), .tx_req(tx_req), .limit_out(limit_out),
    .cnt0(cnt0), .cnt1(cnt1), .sent(sent));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd_val = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(r));
  endtask : rd
  task automatic wait_lim(input int i, input logic v, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      if (limit_out[i] === v) break;
    end
    chk(32'(limit_out[i]), 32'(v));
  endtask : wait_lim
  function automatic logic [31:0] cfg(input logic p, input logic [3:0] on,
    input logic [3:0] off, input logic c, input logic [6:0] cy,
    input logic m);
    chan_cfg_t x;
    x = '{mute: m, cyc: cy, on_chg: c, off_sel: off, on_sel: on, pol: p};
    return 32'(x);
  endfunction : cfg
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    // Disabled channels with polarity 0 show their no-rain value 1
    chk(32'({limit_out, tx_req}), 32'h0000_000C);
    rd(`REG_CTRL, `RESP_OKAY);
    chk(rd_val, 32'h0000_0000);
    rd(8'h10, `RESP_SLVERR);
    chk(rd_val, 32'h0000_0000);
    wr(8'h10, 32'h0000_0007, `RESP_SLVERR);
    wr(`REG_STATUS, 32'h0000_0000, `RESP_SLVERR);
    wr(`REG_CFG1, cfg(1'b1, 4'h0, 4'h0, 1'b1, 7'h00, 1'b0), `RESP_OKAY);
    rd(`REG_CFG1, `RESP_OKAY);
    chk(rd_val, cfg(1'b1, 4'h0, 4'h0, 1'b1, 7'h00, 1'b0));
    wr(`REG_CTRL, 32'h0000_0003, `RESP_OKAY);
    cyc(4);
    b0 = cnt0;
    rain_raw <= 1'b1;
    wait_lim(0, 1'b1, 10);
    rain_raw <= 1'b0;
    wait_lim(0, 1'b0, 10);
    cyc(3);
    chk(32'(cnt0 - b0), 32'h0000_0002);
    chk(32'({limit_out[1], cnt1}), 32'h0000_0100);
    wr(`REG_CFG1, cfg(1'b1, 4'h2, 4'h1, 1'b1, 7'h00, 1'b0), `RESP_OKAY);
    rain_raw <= 1'b1;
    cyc(30);
    chk(32'(limit_out[0]), 32'h0000_0000);
    wait_lim(0, 1'b1, 80);
    rain_raw <= 1'b0;
    cyc(2);
    chk(32'(limit_out[0]), 32'h0000_0001);
    wait_lim(0, 1'b0, 40);
    wr(`REG_CFG1, cfg(1'b1, 4'h0, 4'h0, 1'b0, 7'h01, 1'b0), `RESP_OKAY);
    b0 = cnt0;
    cyc(1000);
    chk(32'(cnt0 - b0 >= 8'h04 && cnt0 - b0 <= 8'h06), 32'h1);
    chk(32'(sent[0]), 32'h0000_0000);
    wr(`REG_CFG1, cfg(1'b1, 4'h0, 4'h0, 1'b0, 7'h00, 1'b0), `RESP_OKAY);
    b0 = cnt0;
    rain_raw <= 1'b1;
    wait_lim(0, 1'b1, 10);
    rain_raw <= 1'b0;
    wait_lim(0, 1'b0, 10);
    cyc(400);
    chk(32'(cnt0 - b0), 32'h0000_0000);
    wr(`REG_CFG1, cfg(1'b1, 4'hD, 4'h0, 1'b0, 7'h01, 1'b0), `RESP_OKAY);
    rain_raw <= 1'b1;
    b0 = cnt0;
    cyc(450);
    chk(32'({sent[0], limit_out[0]}), 32'h0000_0000);
    chk(32'(cnt0 != b0), 32'h0000_0001);
    rain_raw <= 1'b0;
    cyc(10);
    wr(`REG_CFG1, cfg(1'b1, 4'h0, 4'hD, 1'b0, 7'h01, 1'b0), `RESP_OKAY);
    rain_raw <= 1'b1;
    wait_lim(0, 1'b1, 20);
    rain_raw <= 1'b0;
    b0 = cnt0;
    cyc(450);
    chk(32'({sent[0], limit_out[0]}), 32'h0000_0003);
    chk(32'(cnt0 != b0), 32'h0000_0001);
    wr(`REG_CFG1, cfg(1'b1, 4'h0, 4'h0, 1'b1, 7'h00, 1'b0), `RESP_OKAY);
    wr(`REG_CFG2, cfg(1'b0, 4'h0, 4'h0, 1'b1, 7'h00, 1'b0), `RESP_OKAY);
    wr(`REG_CTRL, 32'h0000_0005, `RESP_OKAY);
    cyc(10);
    b0 = cnt0;
    b1 = cnt1;
    supply_ok <= 1'b0;
    cyc(10);
    chk(32'(limit_out), 32'h0000_0001);
    rd(`REG_STATUS, `RESP_OKAY);
    chk(rd_val, 32'h0000_0005);
    chk(32'({cnt0 - b0, cnt1 - b1}), 32'h0000_0202);
    supply_ok <= 1'b1;
    cyc(10);
    chk(32'(limit_out), 32'h0000_0002);
    chk(32'({cnt0 - b0, cnt1 - b1}), 32'h0000_0404);
    wr(`REG_CFG1, cfg(1'b1, 4'h0, 4'h0, 1'b1, 7'h01, 1'b1), `RESP_OKAY);
    b0 = cnt0;
    b1 = cnt1;
    rain_raw <= 1'b1;
    wait_lim(0, 1'b1, 10);
    cyc(450);
    chk(32'(cnt0 - b0), 32'h0000_0000);
    chk(32'({limit_out[1], cnt1 - b1}), 32'h0000_0001);
    rain_raw <= 1'b0;
    wr(`REG_CTRL, 32'h0000_0000, `RESP_OKAY);
    cyc(5);
    b0 = cnt0;
    b1 = cnt1;
    rain_raw <= 1'b1;
    cyc(40);
    rain_raw <= 1'b0;
    cyc(40);
    chk(32'({cnt0 - b0, cnt1 - b1}), 32'h0000_0000);
    end_of_test();
  end
endmodule : tb_top
bind precip_limit_output precip_props PROPS (.*);

// ===== tb/tx_sink.sv
// Stand-in for the bus transmit path: counts send pulses per object
`timescale 1ns/1ns
module tx_sink (
  input wire logic ref_clk,
  input wire logic [1:0] tx_req,
  input wire logic [1:0] limit_out,
  output logic [7:0] cnt0,
  output logic [7:0] cnt1,
  output logic [1:0] sent
);
  initial
  begin
    cnt0 = 8'h00;
    cnt1 = 8'h00;
    sent = 2'b00;
  end
  // The real path cannot refuse a telegram, so every pulse is taken
  always @(posedge ref_clk)
  begin
    if (tx_req[0])
    begin
      cnt0 <= cnt0 + 8'h01;
      sent[0] <= limit_out[0];
    end
    if (tx_req[1])
    begin
      cnt1 <= cnt1 + 8'h01;
      sent[1] <= limit_out[1];
    end
  end
endmodule : tx_sink
